// ==== logic/vip_core.sv ====
`timescale 1ns/1ps
`include "vip_defines.svh"
module vip_core (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // request sources
    input wire logic [`VIP_NUM_HW-1:0] i_hw_request,
    input wire logic [1:0] i_sw_request,
    // control state
    input wire logic [`VIP_NUM_REQ-1:0] i_mask_bits,
    input wire logic i_global_int_enable,
    input wire logic i_exception_level_flag,
    input wire logic i_error_level_flag,
    input wire logic [`VIP_VS_W-1:0] i_vector_spacing,
    input wire logic i_special_vector_select,
    input wire logic i_boot_vector_select,
    input wire logic i_ext_ctrl_present_input,
    input wire logic [`VIP_PTI_W-1:0] i_timer_line_index,
    input wire logic [`VIP_NUM_REQ*`VIP_SS_W-1:0] i_shadow_map,
    // pipeline handshake: ack clears the pending request
    input wire logic i_int_ack,
    // outputs
    output logic o_int_request,
    output logic [`VIP_OFF_W-1:0] o_vector_offset,
    output logic [`VIP_VEC_W-1:0] o_vector_number,
    output logic [`VIP_SS_W-1:0] o_shadow_set,
    output logic [1:0] o_mode,
    output logic o_vectored_mode_present,
    output logic o_external_controller_present,
    output logic [`VIP_PTI_W-1:0] o_timer_line_index
);
    logic [`VIP_NUM_HW-1:0] hw_meta_reg;
    logic [`VIP_NUM_HW-1:0] hw_sync_reg;
    logic ecp_meta_reg;
    logic ecp_sync_reg;
    vip_pkg::vip_req_t pending_bits;
    vip_pkg::vip_req_t masked;
    vip_pkg::vip_mode_t mode_next;
    logic enabled;
    logic fire;
    vip_pkg::vip_off_t off_next;
    logic [`VIP_SS_W-1:0] ss_next;
    vip_enc_if enc_bus ();

    // pins are asynchronous to the core clock
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            hw_meta_reg <= '0;
            hw_sync_reg <= '0;
            ecp_meta_reg <= 1'b0;
            ecp_sync_reg <= 1'b0;
        end else if (i_ce) begin
            hw_meta_reg <= i_hw_request;
            hw_sync_reg <= hw_meta_reg;
            ecp_meta_reg <= i_ext_ctrl_present_input;
            ecp_sync_reg <= ecp_meta_reg;
        end
    end

    // each line lands on its own bit, never decoded as a value
    assign pending_bits = {hw_sync_reg, i_sw_request};

    genvar g;
    generate
        for (g = 0; g < `VIP_NUM_REQ; g++) begin : g_mask
            assign masked[g] = pending_bits[g] & i_mask_bits[g];
        end
    endgenerate

    assign enc_bus.req = masked;
    vip_prio_enc u_enc (
        .enc(enc_bus.enc)
    );

    always_comb begin
        if (i_boot_vector_select || !i_special_vector_select ||
            i_vector_spacing == '0) begin
            mode_next = vip_pkg::VIP_MODE_COMPAT;
        end else if (ecp_sync_reg) begin
            mode_next = vip_pkg::VIP_MODE_EXTERNAL;
        end else begin
            mode_next = vip_pkg::VIP_MODE_VECTORED;
        end
    end

    assign enabled = i_global_int_enable && !i_exception_level_flag &&
                     !i_error_level_flag;
    // external mode is not handled here, so it raises nothing
    assign fire = enc_bus.any && enabled && !o_int_request &&
                  mode_next != vip_pkg::VIP_MODE_EXTERNAL;

    always_comb begin
        if (mode_next == vip_pkg::VIP_MODE_VECTORED) begin
            // spacing counts 32-byte steps; 16 bits hold vector 9 at 31
            off_next = `VIP_VEC_BASE +
                vip_pkg::vip_off_t'(enc_bus.vec) *
                vip_pkg::vip_off_t'({i_vector_spacing, 5'h00});
            ss_next = i_shadow_map[enc_bus.vec*`VIP_SS_W +: `VIP_SS_W];
        end else begin
            // compatibility: single vector, no shadow switch
            off_next = `VIP_VEC_BASE;
            ss_next = '0;
        end
    end

    // offset and shadow set held from raise to ack
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_int_request <= 1'b0;
            o_vector_offset <= `VIP_VEC_BASE;
            o_vector_number <= '0;
            o_shadow_set <= '0;
        end else if (i_ce) begin
            if (fire) begin
                o_int_request <= 1'b1;
                o_vector_offset <= off_next;
                o_vector_number <= enc_bus.vec;
                o_shadow_set <= ss_next;
            end else if (i_int_ack) begin
                o_int_request <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mode <= 2'h0;
            o_vectored_mode_present <= 1'b1;
            o_external_controller_present <= 1'b0;
            o_timer_line_index <= `VIP_PTI_RESET;
        end else if (i_ce) begin
            o_mode <= mode_next;
            o_vectored_mode_present <= 1'b1;
            o_external_controller_present <= ecp_sync_reg;
            o_timer_line_index <= i_timer_line_index;
        end
    end

    property p_no_raise_disabled;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !o_int_request && !(enc_bus.any && enabled))
            |=> !o_int_request;
    endproperty
    a_no_raise_disabled: assert property (p_no_raise_disabled)
        else $error("request raised while disabled or idle");

    property p_hold_offset;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_int_request && !i_int_ack) |=> $stable(o_vector_offset);
    endproperty
    a_hold_offset: assert property (p_hold_offset)
        else $error("latched offset changed while request held");

    property p_offset_calc;
        @(posedge i_clk) disable iff (!i_rstn)
        (fire && i_ce && mode_next == vip_pkg::VIP_MODE_VECTORED) |=>
        o_vector_offset == `VIP_VEC_BASE +
            vip_pkg::vip_off_t'(o_vector_number) *
            vip_pkg::vip_off_t'({$past(i_vector_spacing), 5'h00});
    endproperty
    a_offset_calc: assert property (p_offset_calc)
        else $error("vector offset wrong");

    // map may move after the raise; the latched set must not
    property p_shadow_pick;
        @(posedge i_clk) disable iff (!i_rstn)
        (fire && i_ce && mode_next == vip_pkg::VIP_MODE_VECTORED) |=>
        o_shadow_set ==
            4'($past(i_shadow_map) >> (o_vector_number * `VIP_SS_W));
    endproperty
    a_shadow_pick: assert property (p_shadow_pick)
        else $error("shadow set does not follow its vector");

    property p_top_wins;
        @(posedge i_clk) disable iff (!i_rstn)
        (fire && i_ce && masked[9]) |=> o_vector_number == 4'h9;
    endproperty
    a_top_wins: assert property (p_top_wins)
        else $error("line 7 did not win");

    property p_sw_low;
        @(posedge i_clk) disable iff (!i_rstn)
        (fire && i_ce && |masked[9:2]) |=> o_vector_number >= 4'h2;
    endproperty
    a_sw_low: assert property (p_sw_low)
        else $error("software request beat hardware");

    property p_vpresent;
        @(posedge i_clk) disable iff (!i_rstn) o_vectored_mode_present;
    endproperty
    a_vpresent: assert property (p_vpresent)
        else $error("present flag low");

    property p_compat;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_vector_spacing == '0) |=> o_mode == 2'h0;
    endproperty
    a_compat: assert property (p_compat)
        else $error("zero spacing not compatibility");

    property p_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
        (!o_int_request && !fire) |=> $stable(o_vector_offset);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("offset moved with no request");

    c_raise: cover property (@(posedge i_clk) disable iff (!i_rstn)
        fire ##1 o_int_request);
    c_ack: cover property (@(posedge i_clk) disable iff (!i_rstn)
        o_int_request ##1 !o_int_request);
    c_vect: cover property (@(posedge i_clk) disable iff (!i_rstn)
        o_int_request && o_mode == 2'h1);
    c_ext: cover property (@(posedge i_clk) disable iff (!i_rstn)
        o_mode == 2'h2);
endmodule

// ==== logic/vip_defines.svh ====
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH
`define VIP_NUM_REQ 10
`define VIP_NUM_HW 8
`define VIP_HW_BASE 2
`define VIP_VS_W 5
`define VIP_VEC_W 4
`define VIP_OFF_W 16
`define VIP_VEC_BASE 16'h0200
`define VIP_CMP_OFF_IV0 16'h0180
`define VIP_SS_W 4
`define VIP_PTI_W 3
`define VIP_PTI_RESET 3'h7
`endif

// ==== logic/vip_pkg.sv ====
`include "vip_defines.svh"
package vip_pkg;
    typedef logic [`VIP_NUM_REQ-1:0] vip_req_t;
    typedef logic [`VIP_VEC_W-1:0] vip_vec_t;
    typedef logic [`VIP_OFF_W-1:0] vip_off_t;
    typedef enum logic [1:0] {
        VIP_MODE_COMPAT,
        VIP_MODE_VECTORED,
        VIP_MODE_EXTERNAL
    } vip_mode_t;
endpackage

// ==== logic/vip_enc_if.sv ====
`timescale 1ns/1ps
`include "vip_defines.svh"
interface vip_enc_if;
    vip_pkg::vip_req_t req;
    logic any;
    vip_pkg::vip_vec_t vec;
    modport enc (input req, output any, output vec);
    modport user (output req, input any, input vec);
endinterface

// ==== logic/vip_prio_enc.sv ====
`timescale 1ns/1ps
`include "vip_defines.svh"
module vip_prio_enc (
    vip_enc_if.enc enc
);
    // later (higher) index wins: bit 9 highest, bit 0 lowest
    always_comb begin
        enc.vec = '0;
        for (int i = 0; i < `VIP_NUM_REQ; i++) begin
            if (enc.req[i]) begin
                enc.vec = i[`VIP_VEC_W-1:0];
            end
        end
    end
    assign enc.any = |enc.req;
endmodule

// ==== test/vip_pipe_model.sv ====
`timescale 1ns/1ps
module vip_pipe_model (
    // clock
    input wire logic i_clk,
    // request from core and chosen latency
    input wire logic i_req,
    input wire logic [3:0] i_delay,
    // acknowledge pulse
    output logic o_ack
);
    logic [3:0] cnt_reg;
    initial begin
        o_ack = 1'b0;
        cnt_reg = 4'h0;
    end
    // one pulse per request; never acks the cycle right after its own ack
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        cnt_reg <= (i_req && !o_ack) ? cnt_reg + 4'h1 : 4'h0;
        if (i_req && !o_ack && cnt_reg == i_delay) begin
            o_ack <= 1'b1;
        end
    end
endmodule

// ==== test/vectored_interrupt_prioritizer_test.sv ====
`timescale 1ns/1ps
module vectored_interrupt_prioritizer_test;
    logic i_clk, i_rstn, ack, ie, exception_level_flag, error_level_flag, boot_vector_select, ecp, req, vmp, ecp_o;
    logic iv, ce;
    logic [7:0] hw;
    logic [1:0] sw, mode;
    logic [9:0] mask;
    logic [4:0] vs;
    logic [39:0] smap;
    logic [3:0] dly, num, ss;
    logic [2:0] timer_line_index, pti_o;
    logic [15:0] off;
    logic [23:0] exp_q[$];
    int miscompares, checks_done;
    vip_core i_vip_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_hw_request(hw), .i_sw_request(sw), .i_mask_bits(mask),
        .i_global_int_enable(ie), .i_exception_level_flag(exception_level_flag),
        .i_error_level_flag(error_level_flag), .i_vector_spacing(vs),
        .i_special_vector_select(iv), .i_boot_vector_select(boot_vector_select),
        .i_ext_ctrl_present_input(ecp), .i_timer_line_index(timer_line_index),
        .i_shadow_map(smap), .i_int_ack(ack), .o_int_request(req),
        .o_vector_offset(off), .o_vector_number(num), .o_shadow_set(ss),
        .o_mode(mode), .o_vectored_mode_present(vmp),
        .o_external_controller_present(ecp_o), .o_timer_line_index(pti_o));
    vip_pipe_model i_vip_pipe_model (.i_clk(i_clk), .i_req(req),
        .i_delay(dly), .o_ack(ack));
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (req !== lvl) begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > 40) begin
                miscompares++;
                give_verdict();
            end
        end
    endtask
    task automatic settle;
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // results are judged at the ack edge, after the sources were dropped
    always @(posedge i_clk) begin
        if (i_rstn && ack && req) begin
            if (exp_q.size() == 0) begin
                check(24'h1, 24'h0);
            end else begin
                check({off, num, ss}, exp_q.pop_front());
            end
        end
    end
    initial begin
        logic [9:0] p, m;
        logic [39:0] map;
        logic [4:0] s;
        int v, en;
        {i_rstn, hw, sw, mask, ie, exception_level_flag, error_level_flag, boot_vector_select, ecp, vs, smap} = '0;
        dly = 4'h3;
        iv = 1'b0;
        ce = 1'b1;
        miscompares = 0;
        checks_done = 0;
        v = $urandom(48272);
        timer_line_index = 3'($urandom);
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        settle();
        check(mode, 2'h0);
        check(vmp, 1'b1);
        check(pti_o, timer_line_index);
        for (int i = 0; i < 40; i++) begin
            v = i % 10;
            p = (10'h1 << v) | (10'($urandom) & ((10'h1 << v) - 10'h1));
            m = 10'($urandom) | p;
            s = 5'($urandom % 31 + 1);
            map = {8'($urandom), $urandom};
            en = (i < 10) ? 3 : $urandom % 5;
            @(posedge i_clk);
            {hw, sw} <= p;
            mask <= 10'h0;
            vs <= s;
            smap <= map;
            dly <= 4'($urandom % 10 + 3);
            boot_vector_select <= (i == 0);
            iv <= (i != 1);
            settle();
            check(mode, (i < 2) ? 2'h0 : 2'h1);
            @(posedge i_clk);
            boot_vector_select <= 1'b0;
            iv <= 1'b1;
            mask <= m;
            ie <= en != 0;
            exception_level_flag <= en == 1;
            error_level_flag <= en == 2;
            if (en > 2) begin
                // top set bit wins, software bits lowest
                exp_q.push_back({16'h0200 + 16'(v * (s << 5)), 4'(v),
                    map[4*v +: 4]});
                wait_req(1'b1);
                @(posedge i_clk);
                {hw, sw} <= 10'h0;
                wait_req(1'b0);
            end else begin
                repeat (8) @(posedge i_clk);
                #1;
                check(req, 1'b0);
                @(posedge i_clk);
                {hw, sw} <= 10'h0;
            end
            settle();
        end
        // external mode settles before any request is offered
        @(posedge i_clk);
        ecp <= 1'b1;
        settle();
        check(mode, 2'h2);
        check(ecp_o, 1'b1);
        @(posedge i_clk);
        {ie, exception_level_flag, error_level_flag} <= 3'b100;
        mask <= 10'h3ff;
        sw <= 2'h1;
        repeat (8) @(posedge i_clk);
        #1;
        check(req, 1'b0);
        // enable low must freeze synchronisers and mode alike
        @(posedge i_clk);
        sw <= 2'h0;
        ce <= 1'b0;
        ecp <= 1'b0;
        settle();
        check(ecp_o, 1'b1);
        check(mode, 2'h2);
        @(posedge i_clk);
        ce <= 1'b1;
        settle();
        check(ecp_o, 1'b0);
        check(mode, 2'h1);
        give_verdict();
    end
endmodule
